// ===== logic/low_power_params.svh
// Offsets, field positions, reset values and timing counts of the low-power control block.
`ifndef LOW_POWER_PARAMS_SVH
`define LOW_POWER_PARAMS_SVH
// Printed offsets are not all multiples of four: they are register indices.
`define SLOW_CLOCK_CONFIG_IDX 8'h2e
`define CLOCK_POWER_CONFIG_IDX 8'h39
`define POWER_CONTROL_IDX 8'h3c
`define POWER_STATUS_IDX 8'h3d
// Field positions of clock_power_config.
`define EDGE_SELECT_POS 5
`define STARTUP_DELAY_POS 4
`define CLOCK_MONITOR_POS 3
`define FORCED_MONITOR_POS 2
`define WDOG_RATE_HI_POS 1
`define WDOG_RATE_LO_POS 0
`define CLOCK_POWER_RESET 8'h10
// Field positions of slow_clock_config.
`define SLOW_DIVIDER_POS 0
// Field positions of power_control.
`define SPECIAL_MODE_POS 0
`define WATCHDOG_DISABLE_POS 1
`define SERIAL_PERIPH_EN_POS 2
`define ASYNC_TX_EN_POS 3
`define ASYNC_RX_EN_POS 4
// Write-once window in E-clock cycles.
`define WRITE_ONCE_CYCLES 64
// Slow-mode division ratio.
`define SLOW_DIVIDE 16
// Oscillator stabilization delay in oscillator cycles.
`define STABILIZE_CYCLES 4064
`endif

// ===== logic/low_power_pkg.sv
// Types shared by the low-power control block.
package low_power_pkg;
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_WAIT = 5'h02,
    ST_STOP = 5'h04,
    ST_SETTLE = 5'h08,
    ST_MONRST = 5'h10
  } power_state_e;
  typedef logic [7:0] reg_byte_t;
endpackage

// ===== logic/pin_sync.sv
// Two-flop synchroniser bank for asynchronous pins.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  initial begin
    if (WIDTH < 1) $error("pin_sync needs WIDTH of at least 1");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else if (clk_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // pin_sync

// ===== logic/slow_divider.sv
// Divide-by-N enable generator for slow mode.
`timescale 1ns/1ps
`include "low_power_params.svh"
module slow_divider #(
  parameter int DIVIDE = `SLOW_DIVIDE
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Control
  input wire logic slow,
  output logic tick
);
  localparam int CW = $clog2(DIVIDE);
  logic [CW-1:0] count;

  initial begin
    if (DIVIDE < 2) $error("slow_divider needs DIVIDE of at least 2");
  end

  // Counter restarts whenever slow mode is off so the first slow tick is a full period away.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clk_en) begin
      if (!slow || count == CW'(DIVIDE - 1)) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  assign tick = !slow || count == CW'(DIVIDE - 1);
endmodule // slow_divider

// ===== logic/low_power_ctrl.sv
// Low-power mode control: wait, stop and slow mode with APB register access.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "low_power_params.svh"
// Overview of operation
// (R1) Suspend instruction stacks registers, halts processor, oscillator keeps running until interrupt.
// (R2) While waiting, repeatedly read the stacked condition code address.
// (R3) Any unmasked interrupt request ends wait; here a pending edge-triggered request (irq_edge_pending) does not end wait.
// (R4) Timer stops in wait only if interrupt mask set and watchdog disabled.
// (R5) In wait, serial, transmit and receive clocks off when their enables clear.
// (R6) Stop halts every clock including the oscillator; slow_tick stays high in stop.
// (R7) Stop entered only if stop-disable flag clear, else no-operation.
// (R8) Low on maskable, non-maskable or reset pin ends stop.
// (R9) A pending edge-triggered maskable request also ends stop.
// (R10) Stop keeps processor state, memory and pin levels unchanged.
// (R11) Reset ending stop runs the normal reset sequence.
// (R12) Maskable pin wakes from stop only while interrupt mask clear.
// (R13) Non-maskable pin always wakes; service runs only if its mask clear.
// (R14) Clock monitor enabled at stop entry produces a clock monitor reset.
// (R15) Stabilization delay on stop exit when startup-delay bit is one.
// (R16) Reset sets startup-delay bit; one write within 64 cycles in normal modes.
// (R17) Delay always follows power-on reset, never a running-clock reset.
// (R18) Protected option bits write once within 64 cycles, anytime in special modes.
// (R19) Slow bit inserts divide-by-16 before the internal clock.
// (R20) Slow bit read/write anytime; writing zero restores full speed.
// (R21) Hardware clears slow bit on stop entry and on any reset.
// (R22) Software avoids clock monitor when E clock falls below 200 kHz.
// (R23) Stabilization delay is a parameterized oscillator cycle count holding the processor.
module low_power_ctrl
  import low_power_pkg::*;
#(
  parameter int STABILIZE = `STABILIZE_CYCLES,
  parameter int WRITE_WINDOW = `WRITE_ONCE_CYCLES
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic power_on,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor core
  input wire logic suspend_instruction,
  input wire logic stop_instruction,
  input wire logic stop_disable,
  input wire logic irq_mask,
  input wire logic nonmaskable_int_pin_mask,
  input wire logic [15:0] stacked_ccr_addr,
  input wire logic periph_int_req,
  input wire logic irq_edge_pending,
  output logic cpu_hold,
  output logic stack_request,
  output logic wait_bus_read,
  output logic [15:0] wait_bus_addr,
  output logic nonmaskable_int_pin_service,
  output low_power_pkg::reg_byte_t cpu_state_hold,
  // Pins
  input wire logic maskable_int_pin_n,
  input wire logic nonmaskable_int_pin_n,
  input wire logic reset_pin_n,
  // Clock gates and resets
  output logic osc_enable,
  output logic sys_clk_enable,
  output logic timer_clk_enable,
  output logic spi_clk_enable,
  output logic tx_clk_enable,
  output logic rx_clk_enable,
  output logic slow_tick,
  output logic clock_monitor_reset,
  output logic system_reset_req,
  output logic edge_select_bit,
  output logic clock_monitor_enable,
  output logic forced_clock_monitor_enable,
  output logic watchdog_rate_hi,
  output logic watchdog_rate_lo
);
  import low_power_pkg::*;

  localparam int SW = $clog2(STABILIZE + 1);
  localparam int WW = $clog2(WRITE_WINDOW + 1);
  localparam logic [7:0] CLOCK_POWER_INIT = `CLOCK_POWER_RESET;

  initial begin
    if (STABILIZE < 1) $error("STABILIZE must be at least 1");
    if (WRITE_WINDOW < 1) $error("WRITE_WINDOW must be at least 1");
  end

  power_state_e state;
  power_state_e next_state;
  logic irq_n_s;
  logic nonmaskable_int_pin_n_s;
  logic rst_n_s;
  logic [SW-1:0] settle_count;
  logic [WW-1:0] window_count;
  logic window_open;
  logic options_written;
  logic startup_delay_bit;
  logic slow_divider_bit;
  logic special_mode;
  logic watchdog_disable_bit;
  logic serial_periph_enable;
  logic async_tx_enable;
  logic async_rx_enable;
  logic por_pending;
  logic wait_wake;
  logic stop_wake;
  logic stop_enter;
  logic wr_access;
  logic rd_access;
  logic [7:0] reg_index;
  logic addr_valid;
  logic [7:0] read_byte;
  logic tick;

  pin_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'h7)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in({maskable_int_pin_n, nonmaskable_int_pin_n, reset_pin_n}),
    .sync_out({irq_n_s, nonmaskable_int_pin_n_s, rst_n_s})
  );

  slow_divider #(
    .DIVIDE(`SLOW_DIVIDE)
  ) u_slow_divider (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .slow(slow_divider_bit),
    .tick(tick)
  );

  // APB decode; registers are byte-wide at word addresses of four times their index.
  assign reg_index = paddr[9:2];
  assign addr_valid = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 &&
    (reg_index == `SLOW_CLOCK_CONFIG_IDX || reg_index == `CLOCK_POWER_CONFIG_IDX ||
     reg_index == `POWER_CONTROL_IDX || reg_index == `POWER_STATUS_IDX);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_valid;
  assign wr_access = clk_en && psel && penable && pwrite && addr_valid;
  // Read data is loaded in the setup cycle so that it already stands in the zero-wait access phase.
  assign rd_access = clk_en && psel && !penable && !pwrite && addr_valid;

  // Wake qualification.
  assign wait_wake = (!irq_n_s && !irq_mask) || (!nonmaskable_int_pin_n_s && !nonmaskable_int_pin_mask) || (periph_int_req && !irq_mask); // (R3)
  assign stop_wake = (!irq_n_s && !irq_mask) || (irq_edge_pending && !irq_mask) || !nonmaskable_int_pin_n_s; // (R8) (R9) (R12) (R13)
  assign stop_enter = stop_instruction && !stop_disable; // (R7)

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (por_pending && power_on) begin
          next_state = ST_SETTLE; // (R17)
        end else if (suspend_instruction) begin
          next_state = ST_WAIT; // (R1)
        end else if (stop_enter) begin
          next_state = (clock_monitor_enable || forced_clock_monitor_enable) ? ST_MONRST : ST_STOP; // (R14)
        end
      end
      ST_WAIT: begin
        if (wait_wake) begin
          next_state = ST_RUN; // (R3)
        end
      end
      ST_STOP: begin
        if (stop_wake) begin
          next_state = startup_delay_bit ? ST_SETTLE : ST_RUN; // (R15)
        end
      end
      ST_SETTLE: begin
        if (settle_count == '0) begin
          next_state = ST_RUN; // (R23)
        end
      end
      ST_MONRST: begin
        next_state = ST_MONRST;
      end
    endcase
  end

  // A reset pin low while stopped is handed out as a system reset; the core then resets this block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Power-on reset always settles the oscillator; a warm reset does not.
  // The flag marks the first enabled cycle after reset, when power_on is judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_pending <= 1'b1;
    end else if (clk_en) begin
      por_pending <= 1'b0; // (R17)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_count <= SW'(STABILIZE);
    end else if (clk_en) begin
      if (state == ST_STOP || por_pending) begin
        settle_count <= SW'(STABILIZE); // (R23)
      end else if (state == ST_SETTLE && settle_count != '0) begin
        settle_count <= settle_count - 1'b1;
      end
    end
  end

  // Write-once window counts E-clock cycles, so it stretches under slow mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_count <= '0;
    end else if (clk_en && tick && window_count != WW'(WRITE_WINDOW)) begin
      window_count <= window_count + 1'b1;
    end
  end
  assign window_open = window_count != WW'(WRITE_WINDOW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      options_written <= 1'b0;
      startup_delay_bit <= CLOCK_POWER_INIT[`STARTUP_DELAY_POS];
      edge_select_bit <= 1'b0;
      forced_clock_monitor_enable <= 1'b0;
      watchdog_rate_hi <= 1'b0;
      watchdog_rate_lo <= 1'b0;
      clock_monitor_enable <= 1'b0;
    end else if (wr_access && reg_index == `CLOCK_POWER_CONFIG_IDX) begin
      clock_monitor_enable <= pwdata[`CLOCK_MONITOR_POS];
      if (special_mode || (window_open && !options_written)) begin // (R16) (R18)
        options_written <= !special_mode;
        edge_select_bit <= pwdata[`EDGE_SELECT_POS];
        startup_delay_bit <= pwdata[`STARTUP_DELAY_POS]; // (R15)
        forced_clock_monitor_enable <= pwdata[`FORCED_MONITOR_POS];
        watchdog_rate_hi <= pwdata[`WDOG_RATE_HI_POS];
        watchdog_rate_lo <= pwdata[`WDOG_RATE_LO_POS];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_divider_bit <= 1'b0; // (R21)
    end else if (clk_en) begin
      if (state == ST_RUN && stop_enter) begin
        slow_divider_bit <= 1'b0; // (R21)
      end else if (wr_access && reg_index == `SLOW_CLOCK_CONFIG_IDX) begin
        slow_divider_bit <= pwdata[`SLOW_DIVIDER_POS]; // (R20)
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_mode <= 1'b0;
      watchdog_disable_bit <= 1'b0;
      serial_periph_enable <= 1'b0;
      async_tx_enable <= 1'b0;
      async_rx_enable <= 1'b0;
    end else if (wr_access && reg_index == `POWER_CONTROL_IDX) begin
      special_mode <= pwdata[`SPECIAL_MODE_POS];
      watchdog_disable_bit <= pwdata[`WATCHDOG_DISABLE_POS];
      serial_periph_enable <= pwdata[`SERIAL_PERIPH_EN_POS];
      async_tx_enable <= pwdata[`ASYNC_TX_EN_POS];
      async_rx_enable <= pwdata[`ASYNC_RX_EN_POS];
    end
  end

  always_comb begin
    read_byte = 8'h00;
    if (reg_index == `SLOW_CLOCK_CONFIG_IDX) begin
      read_byte[`SLOW_DIVIDER_POS] = slow_divider_bit;
    end else if (reg_index == `CLOCK_POWER_CONFIG_IDX) begin
      read_byte[`EDGE_SELECT_POS] = edge_select_bit;
      read_byte[`STARTUP_DELAY_POS] = startup_delay_bit;
      read_byte[`CLOCK_MONITOR_POS] = clock_monitor_enable;
      read_byte[`FORCED_MONITOR_POS] = forced_clock_monitor_enable;
      read_byte[`WDOG_RATE_HI_POS] = watchdog_rate_hi;
      read_byte[`WDOG_RATE_LO_POS] = watchdog_rate_lo;
    end else if (reg_index == `POWER_CONTROL_IDX) begin
      read_byte = {3'h0, async_rx_enable, async_tx_enable, serial_periph_enable, watchdog_disable_bit,
        special_mode};
    end else if (reg_index == `POWER_STATUS_IDX) begin
      read_byte = {2'h0, window_open, state};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_access) begin
      prdata <= {24'h0, read_byte};
    end
  end

  // Processor-facing data outputs are registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_bus_addr <= 16'h0;
      nonmaskable_int_pin_service <= 1'b0;
      cpu_state_hold <= 8'h00;
    end else if (clk_en) begin
      if (state == ST_RUN && suspend_instruction) begin
        wait_bus_addr <= stacked_ccr_addr; // (R2)
      end
      nonmaskable_int_pin_service <= state == ST_STOP && !nonmaskable_int_pin_n_s && !nonmaskable_int_pin_mask; // (R13)
      cpu_state_hold <= {3'h0, state}; // (R10)
    end
  end

  assign stack_request = state == ST_RUN && suspend_instruction; // (R1)
  assign wait_bus_read = state == ST_WAIT && tick; // (R2)
  assign cpu_hold = state != ST_RUN || (por_pending && power_on); // (R10) (R23)
  assign osc_enable = state != ST_STOP; // (R1) (R6)
  assign sys_clk_enable = (state == ST_RUN) && tick; // (R6) (R19)
  assign timer_clk_enable = tick && (state == ST_RUN ||
    (state == ST_WAIT && !(irq_mask && watchdog_disable_bit))); // (R4)
  assign spi_clk_enable = tick && (state == ST_RUN || (state == ST_WAIT && serial_periph_enable)); // (R5)
  assign tx_clk_enable = tick && (state == ST_RUN || (state == ST_WAIT && async_tx_enable)); // (R5)
  assign rx_clk_enable = tick && (state == ST_RUN || (state == ST_WAIT && async_rx_enable)); // (R5)
  assign slow_tick = tick; // (R19)
  assign clock_monitor_reset = state == ST_MONRST; // (R14)
  assign system_reset_req = state == ST_MONRST || (state == ST_STOP && !rst_n_s); // (R11)
endmodule // low_power_ctrl

// ===== tb/low_power_ctrl_properties.sv
// Concurrent checks on the ports of the low-power control block.
`timescale 1ns/1ps
module low_power_ctrl_properties (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Register bus
  input logic psel,
  input logic penable,
  input logic [11:0] paddr,
  input logic pready,
  input logic pslverr,
  // Core side
  input logic suspend_instruction,
  input logic stop_instruction,
  input logic stop_disable,
  input logic irq_mask,
  input logic [15:0] stacked_ccr_addr,
  input logic periph_int_req,
  input logic nonmaskable_int_pin_n,
  input logic cpu_hold,
  input logic wait_bus_read,
  input logic [15:0] wait_bus_addr,
  // Clock gates and monitor
  input logic osc_enable,
  input logic timer_clk_enable,
  input logic clock_monitor_reset,
  input logic clock_monitor_enable,
  input logic forced_clock_monitor_enable
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence wait_go;
    suspend_instruction && !stop_instruction && !cpu_hold;
  endsequence
  sequence stop_go;
    stop_instruction && !suspend_instruction && !stop_disable && !cpu_hold;
  endsequence
  sequence stop_held;
    !osc_enable && !clock_monitor_reset;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_decode_err: assert property (psel && penable |-> pslverr == !(paddr inside {12'h0b8, 12'h0e4, 12'h0f0, 12'h0f4}))
    else $error("pslverr does not match decode");
  a_wait_entry: assert property (wait_go |=> wait_bus_read && cpu_hold && osc_enable) else $error("wait entry");
  a_wait_addr: assert property (wait_go |=> wait_bus_addr == $past(stacked_ccr_addr)) else $error("wait addr");
  a_wait_wake: assert property (wait_bus_read && periph_int_req && !irq_mask |-> ##[1:4] !wait_bus_read)
    else $error("wait not left");
  a_timer_run: assert property (wait_bus_read && !irq_mask |-> timer_clk_enable) else $error("timer gated");
  a_stop_halt: assert property (stop_go ##0 (!clock_monitor_enable && !forced_clock_monitor_enable)
    |=> stop_held ##0 cpu_hold) else $error("stop entry");
  a_stop_nop: assert property (stop_instruction && stop_disable && !cpu_hold |=> osc_enable && !cpu_hold)
    else $error("stop not ignored");
  a_stop_wake: assert property (stop_held ##0 !nonmaskable_int_pin_n |-> ##[1:4] osc_enable)
    else $error("stop not left");
  a_monitor_reset: assert property (stop_go ##0 (clock_monitor_enable || forced_clock_monitor_enable)
    |=> clock_monitor_reset [*3]) else $error("no monitor reset");
endmodule // low_power_ctrl_properties
bind low_power_ctrl low_power_ctrl_properties i_low_power_ctrl_properties (.*);

// ===== tb/tb_low_power_ctrl.sv
// Self-checking bench for the low-power control block.
`timescale 1ns/1ps
`include "low_power_params.svh"
module tb_low_power_ctrl;
  import low_power_pkg::*;
  localparam int STAB = 16;
  localparam logic [11:0] A_SLOW = {2'h0, `SLOW_CLOCK_CONFIG_IDX, 2'h0};
  localparam logic [11:0] A_OPT = {2'h0, `CLOCK_POWER_CONFIG_IDX, 2'h0};
  localparam logic [11:0] A_CTL = {2'h0, `POWER_CONTROL_IDX, 2'h0};
  logic pclk = 0, presetn = 0, clk_en = 1, power_on = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, suspend_instruction = 0, stop_instruction = 0, stop_disable = 0;
  logic irq_mask = 1, nonmaskable_int_pin_mask = 1, periph_int_req = 0, irq_edge_pending = 0, reset_pin_n = 1;
  logic maskable_int_pin_n = 1, nonmaskable_int_pin_n = 1;
  logic [15:0] stacked_ccr_addr = '0, wait_bus_addr;
  logic cpu_hold, stack_request, wait_bus_read, nonmaskable_int_pin_service, osc_enable, sys_clk_enable, timer_clk_enable;
  logic spi_clk_enable, tx_clk_enable, rx_clk_enable, slow_tick, clock_monitor_reset, system_reset_req;
  logic edge_select_bit, clock_monitor_enable, forced_clock_monitor_enable, watchdog_rate_hi, watchdog_rate_lo;
  reg_byte_t cpu_state_hold;
  logic [31:0] exp_q[$], got_q[$];
  int failures = 0, comparisons = 0, cyc = 0, n;
  always #12.5 pclk = ~pclk;
  // Short counts keep the settle and write-window phases within a few cycles.
  low_power_ctrl #(.STABILIZE(STAB), .WRITE_WINDOW(8)) i_low_power_ctrl (.*);
  task automatic test_done;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    got_q.push_back(got);
    exp_q.push_back(exp);
  endtask
  initial forever begin
    wait (exp_q.size() > 0);
    comparisons++;
    if (got_q[0] !== exp_q[0]) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got_q[0], exp_q[0]);
    end
    void'(got_q.pop_front());
    void'(exp_q.pop_front());
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      test_done;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    err = pslverr;
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic instr(input logic s);
    if (s) stop_instruction <= 1;
    else suspend_instruction <= 1;
    @(posedge pclk);
    stop_instruction <= 0;
    suspend_instruction <= 0;
  endtask
  task automatic until_run;
    n = 0;
    while (cpu_hold !== 1'b0) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic do_reset(input logic po);
    presetn <= 0;
    power_on <= po;
    repeat (12) @(posedge pclk);
    presetn <= 1;
  endtask
  initial begin
    void'($urandom(32'h27c84a83));
    @(posedge pclk);
    do_reset(1'b1);
    apb(1, A_OPT, 8'h24);
    apb(1, A_OPT, 8'h18);
    apb(0, A_OPT, 8'h00);
    chk(rd, 32'h2c);
    chk({edge_select_bit, forced_clock_monitor_enable, clock_monitor_enable}, 3'b111);
    apb(0, 12'h004, 8'h00);
    chk(err, 1'b1);
    chk(cpu_hold, 1'b1);
    until_run;
    instr(1'b1);
    repeat (2) @(posedge pclk);
    chk(clock_monitor_reset, 1'b1);
    do_reset(1'b0);
    apb(0, A_OPT, 8'h00);
    chk(rd, 32'h10);
    chk(cpu_hold, 1'b0);
    repeat (20) @(posedge pclk);
    apb(1, A_OPT, 8'h00);
    apb(0, A_OPT, 8'h00);
    chk(rd, 32'h10);
    apb(1, A_SLOW, 8'h01);
    apb(0, A_SLOW, 8'h00);
    chk(rd, 32'h1);
    n = 0;
    repeat (64) begin
      @(posedge pclk);
      n += slow_tick;
    end
    chk(n, 4);
    instr(1'b1);
    @(posedge pclk);
    chk({osc_enable, sys_clk_enable, cpu_hold}, 3'b001);
    nonmaskable_int_pin_n <= 0;
    until_run;
    chk(n >= STAB, 1'b1);
    chk(nonmaskable_int_pin_service, 1'b0);
    nonmaskable_int_pin_n <= 1;
    @(posedge pclk);
    apb(0, A_SLOW, 8'h00);
    chk(rd, 32'h0);
    apb(1, A_CTL, 8'h02);
    stacked_ccr_addr <= 16'($urandom);
    instr(1'b0);
    @(posedge pclk);
    chk({wait_bus_read, cpu_hold, osc_enable}, 3'b111);
    chk(wait_bus_addr, stacked_ccr_addr);
    chk({timer_clk_enable, spi_clk_enable, tx_clk_enable, rx_clk_enable}, 4'h0);
    irq_mask <= 0;
    repeat (2) @(posedge pclk);
    chk(timer_clk_enable, 1'b1);
    periph_int_req <= 1;
    until_run;
    chk(n < 5, 1'b1);
    periph_int_req <= 0;
    irq_mask <= 1;
    apb(1, A_CTL, 8'h01);
    apb(1, A_OPT, 8'h00);
    apb(0, A_OPT, 8'h00);
    chk(rd, 32'h0);
    stop_disable <= 1;
    instr(1'b1);
    @(posedge pclk);
    chk(cpu_hold, 1'b0);
    stop_disable <= 0;
    instr(1'b1);
    maskable_int_pin_n <= 0;
    repeat (8) @(posedge pclk);
    chk(osc_enable, 1'b0);
    irq_mask <= 0;
    until_run;
    chk(n < STAB, 1'b1);
    maskable_int_pin_n <= 1;
    irq_mask <= 1;
    nonmaskable_int_pin_mask <= 0;
    @(posedge pclk);
    instr(1'b1);
    @(posedge pclk);
    nonmaskable_int_pin_n <= 0;
    until_run;
    chk(nonmaskable_int_pin_service, 1'b1);
    nonmaskable_int_pin_n <= 1;
    irq_mask <= 0;
    // Let the released pin pass the synchroniser before stopping again.
    repeat (3) @(posedge pclk);
    instr(1'b1);
    @(posedge pclk);
    irq_edge_pending <= 1;
    until_run;
    chk(n < 4, 1'b1);
    irq_edge_pending <= 0;
    instr(1'b1);
    @(posedge pclk);
    reset_pin_n <= 0;
    repeat (3) @(posedge pclk);
    chk({osc_enable, system_reset_req}, 2'b01);
    reset_pin_n <= 1;
    do_reset(1'b0);
    apb(0, A_OPT, 8'h00);
    chk(rd, 32'h10);
    repeat (4) @(posedge pclk);
    wait (exp_q.size() == 0);
    test_done;
  end
endmodule // tb_low_power_ctrl
